// *** bench/svm_monitor_tb.sv ***
// Purpose: self-checking bench for the supply voltage monitor
// Assumes: comparator inputs driven directly, register port driven by tasks
// Notes: filter waits span several 2000-cycle sample periods
`timescale 1ns/1ns
module svm_monitor_tb;
  import svm_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [NUM_CMP-1:0] cmp_in = 3'h0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata_q;
  logic irq_q, por_rst_q, mon0_rst_q, mon1_rst_q;
  int fail_count = 0;
  int n_tests = 0;
  logic [7:0] d;

  svm_monitor u_dut (.mclk(mclk), .srst(srst), .cmp_in(cmp_in), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .irq_q(irq_q), .por_rst_q(por_rst_q), .mon0_rst_q(mon0_rst_q),
    .mon1_rst_q(mon1_rst_q));

  initial begin
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata_q;
  endtask

  task automatic setc(input int i, input logic v);
    @(posedge mclk);
    cmp_in[i] <= v;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return irq_q;
      1: return por_rst_q;
      2: return mon0_rst_q;
      default: return mon1_rst_q;
    endcase
  endfunction

  // wait up to n cycles for output s to reach v
  task automatic wt(input int s, input logic v, input int n);
    logic ok;
    ok = 1'b0;
    for (int k = 0; k < n && !ok; k++) begin
      @(posedge mclk);
      #1 ok = (pick(s) === v);
    end
    chk({7'h00, pick(s)}, {7'h00, v});
  endtask

  // output s must keep value v for n cycles
  task automatic hold(input int s, input logic v, input int n);
    logic bad;
    bad = 1'b0;
    for (int k = 0; k < n; k++) begin
      @(posedge mclk);
      #1 if (pick(s) !== v) bad = 1'b1;
    end
    chk({7'h00, bad}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power;
    chk({7'h00, por_rst_q}, 8'h01);
    wt(2, 1'b1, 8);
    rd_reg(MON0_CTL_OFS, d);
    chk(d & 8'h01, 8'h01);
    rd_reg(MON1_CTL_OFS, d);
    chk(d, 8'h00);
    rd_reg(4'hF, d);
    chk(d, 8'h00);
    setc(0, 1'b1);
    wt(1, 1'b0, 8);
    wt(2, 1'b0, 8);
    wr_reg(MON0_CTL_OFS, 8'h00);
    setc(0, 1'b0);
    hold(2, 1'b0, 10);
    wr_reg(MON0_CTL_OFS, 8'h01);
    wt(2, 1'b1, 4);
    setc(0, 1'b1);
    wt(2, 1'b0, 8);
    hold(1, 1'b0, 4);
    $display("test power done");
  endtask

  task automatic t_mon2;
    wr_reg(INT_EN_OFS, 8'h02);
    wr_reg(MON2_CTL_OFS, 8'h01);
    setc(2, 1'b1);
    hold(0, 1'b0, 2);
    wt(0, 1'b1, 6);
    rd_reg(MON2_CTL_OFS, d);
    chk(d & 8'h04, 8'h04);
    rd_reg(DET_STS_OFS, d);
    chk(d & 8'h08, 8'h08);
    rd_reg(INT_STS_OFS, d);
    chk(d & 8'h03, 8'h02);
    wr_reg(INT_CLR_OFS, 8'h02);
    wt(0, 1'b0, 3);
    wr_reg(MON2_CTL_OFS, 8'h81);
    hold(0, 1'b0, 8);
    setc(2, 1'b0);
    wt(0, 1'b1, 8);
    rd_reg(DET_STS_OFS, d);
    chk(d & 8'h08, 8'h00);
    wr_reg(INT_CLR_OFS, 8'h02);
    wr_reg(MON2_CTL_OFS, 8'h81);
    setc(2, 1'b1);
    hold(0, 1'b0, 10);
    wr_reg(MON2_CTL_OFS, 8'h80);
    setc(2, 1'b0);
    hold(0, 1'b0, 10);
    rd_reg(MON2_CTL_OFS, d);
    chk(d & 8'h05, 8'h04);
    rd_reg(INT_STS_OFS, d);
    chk(d & 8'h02, 8'h00);
    $display("test monitor2 done");
  endtask

  task automatic t_mon1;
    wr_reg(INT_EN_OFS, 8'h01);
    wr_reg(MON1_CTL_OFS, 8'h82);
    setc(1, 1'b1);
    hold(0, 1'b0, 10);
    setc(1, 1'b0);
    hold(0, 1'b0, 10);
    rd_reg(MON1_CTL_OFS, d);
    chk(d & 8'h04, 8'h04);
    wr_reg(MON1_CTL_OFS, 8'h82);
    rd_reg(MON1_CTL_OFS, d);
    chk(d & 8'h04, 8'h00);
    wr_reg(MON1_CTL_OFS, 8'h03);
    setc(1, 1'b1);
    wt(0, 1'b1, 8);
    rd_reg(INT_STS_OFS, d);
    chk(d & 8'h03, 8'h01);
    // filter on, let the filtered level settle first
    wr_reg(MON1_CTL_OFS, 8'h81);
    repeat (8200) @(posedge mclk);
    wr_reg(MON1_CTL_OFS, 8'h81);
    wr_reg(INT_CLR_OFS, 8'h01);
    setc(1, 1'b0);
    hold(0, 1'b0, 100);
    wt(0, 1'b1, 8200);
    wr_reg(INT_CLR_OFS, 8'h01);
    wr_reg(MON1_CTL_OFS, 8'h43);
    setc(1, 1'b1);
    wt(3, 1'b1, 8);
    chk({7'h00, irq_q}, 8'h00);
    rd_reg(INT_STS_OFS, d);
    chk(d & 8'h01, 8'h00);
    $display("test monitor1 done");
  endtask

  // ----------------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    t_power();
    t_mon2();
    t_mon1();
    close_out();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
endmodule

// *** common/svm_pkg.sv ***
// Purpose: shared constants and types for the supply voltage monitor
// Assumes: 8-bit register port, 4-bit register address
// Notes: comparator inputs are high while the supply is at or above a level
package svm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] MON1_CTL_OFS = 4'h0;
  localparam logic [3:0] MON2_CTL_OFS = 4'h1;
  localparam logic [3:0] DET_STS_OFS = 4'h2;
  localparam logic [3:0] INT_STS_OFS = 4'h3;
  localparam logic [3:0] INT_CLR_OFS = 4'h4;
  localparam logic [3:0] INT_EN_OFS = 4'h5;
  localparam logic [3:0] MON0_CTL_OFS = 4'h6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LVL0_POS = 1;
  localparam int LVL1_POS = 2;
  localparam int ABOVE2_POS = 3;
  localparam int INT_MON1_POS = 0;
  localparam int INT_MON2_POS = 1;
  localparam int MON0_EN_POS = 0;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic MON0_EN_RST = 1'b1;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [1:0] INT_RST = 2'h0;
  localparam int FILT_PERIOD_NS = 8000;
  localparam int CLK_PERIOD_NS = 4;
  localparam logic [11:0] FILT_DIV_CYC = 12'(FILT_PERIOD_NS / CLK_PERIOD_NS);
  localparam int FILT_TAPS = 3;
  localparam int NUM_CMP = 3;

  // ----------------------------------------------------------------
  // control register and bus layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       direction_sel;
    logic       action_sel;
    logic [2:0] unused;
    logic       crossing_flag;
    logic       filter_bypass;
    logic       request_en;
  } svm_ctl_type;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } svm_bus_type;

endpackage

// *** core/svm_cmp_cond.sv ***
// Purpose: synchronise one comparator output and optionally filter it
// Assumes: sample tick is a one-cycle pulse on mclk
// Notes: filtered level changes after FILT_TAPS equal samples
`timescale 1ns/1ns
module svm_cmp_cond
  import svm_pkg::*;
(
  input wire logic mclk,     // system clock
  input wire logic srst,     // synchronous reset
  input wire logic cmp_in,   // asynchronous comparator output
  input wire logic bypass,   // 1: skip the filter
  input wire logic tick,     // filter sample strobe
  output logic     level_q   // conditioned level
);

  logic meta_q;
  logic sync_q;
  logic [FILT_TAPS-1:0] samp_q;
  logic filt_q;

  // ----------------------------------------------------------------
  // two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= cmp_in;
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------------------------------
  // sampling filter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      samp_q <= '0;
      filt_q <= 1'b0;
    end else if (tick) begin
      samp_q <= {samp_q[FILT_TAPS-2:0], sync_q};
      if (&samp_q) filt_q <= 1'b1;
      else if (~|samp_q) filt_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) level_q <= 1'b0;
    else level_q <= bypass ? sync_q : filt_q;
  end

endmodule

// *** core/svm_monitor.sv ***
// Purpose: digital side of a three-level supply voltage monitor
// Assumes: comparator inputs high while supply is at or above the level
// Notes: register reads return data in the cycle after the strobe
//
// Operation
// - enabled monitor requests interrupt on crossing in selected direction.
// - monitors 1 and 2 each keep a readable crossing flag.
// - monitor 2 direction 0 arms upward, 1 arms downward passage.
// - monitor 1 direction 0 arms upward, 1 arms downward passage.
// - level-0 monitor resets chip while enabled and supply below level 0.
// - power-on reset releases once supply reaches level 0.
// - read-only live bit shows supply at or above level 2.
// - monitor 1 action 0 routes crossing to interrupt, 1 to reset.
// - monitor 1 enable 1 allows request; 0 blocks any request.
// - monitor 1 filter bit 1 bypasses the filter, 0 uses it.
// - flag sets even when disabled; software clears it by writing 0.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module svm_monitor
  import svm_pkg::*;
(
  input wire logic mclk,                   // system clock, 250 MHz
  input wire logic srst,                   // synchronous reset, active high
  input wire logic [NUM_CMP-1:0] cmp_in,   // comparators for levels 0..2
  input wire logic [ADDR_W-1:0] addr,      // register address
  input wire logic [DATA_W-1:0] wdata,     // write data
  input wire logic wr,                     // write strobe
  input wire logic rd,                     // read strobe
  output logic [DATA_W-1:0] rdata_q,       // read data, cycle after rd
  output logic irq_q,                      // level interrupt request
  output logic por_rst_q,                  // power-on reset, active high
  output logic mon0_rst_q,                 // level-0 monitor reset
  output logic mon1_rst_q                  // monitor 1 reset request
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  svm_bus_type bus;
  svm_ctl_type m1_q;
  svm_ctl_type m1_d;
  svm_ctl_type m2_q;
  svm_ctl_type m2_d;
  logic m0_en_q;
  logic [1:0] ists_q;
  logic [1:0] ists_d;
  logic [1:0] ien_q;
  logic [NUM_CMP-1:0] lvl;
  logic [NUM_CMP-1:0] lvl_prev_q;
  logic [NUM_CMP-1:0] byp;
  logic [11:0] div_q;
  logic tick_q;
  logic m1_cross;
  logic m2_cross;
  logic m1_irq_ev;
  logic m2_irq_ev;
  logic m1_rst_ev;
  logic [DATA_W-1:0] rd_mux;

  assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  // ----------------------------------------------------------------
  // crossing decode
  // ----------------------------------------------------------------
  function automatic logic crossed(input logic prev, input logic cur, input logic dir);
    crossed = dir ? (prev & ~cur) : (~prev & cur);
  endfunction

  function automatic logic hit(input svm_bus_type b, input logic [3:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // filter sample strobe
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == FILT_DIV_CYC - 12'h001) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 12'h001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // comparator conditioning
  // ----------------------------------------------------------------
  assign byp[0] = 1'b1;
  assign byp[1] = m1_q.filter_bypass;
  assign byp[2] = 1'b1;

  generate
    for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
      svm_cmp_cond u_cond (
        .mclk(mclk),
        .srst(srst),
        .cmp_in(cmp_in[i]),
        .bypass(byp[i]),
        .tick(tick_q),
        .level_q(lvl[i])
      );
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (srst) lvl_prev_q <= '0;
    else lvl_prev_q <= lvl;
  end

  assign m1_cross = crossed(lvl_prev_q[1], lvl[1], m1_q.direction_sel);
  assign m2_cross = crossed(lvl_prev_q[2], lvl[2], m2_q.direction_sel);
  assign m1_irq_ev = m1_cross && m1_q.request_en && !m1_q.action_sel;
  assign m1_rst_ev = m1_cross && m1_q.request_en && m1_q.action_sel;
  assign m2_irq_ev = m2_cross && m2_q.request_en;

  // ----------------------------------------------------------------
  // monitor control registers
  // ----------------------------------------------------------------
  always_comb begin
    m1_d = m1_q;
    if (hit(bus, MON1_CTL_OFS)) begin
      m1_d = svm_ctl_type'(bus.wdata);
      m1_d.unused = 3'h0;
      m1_d.crossing_flag = m1_q.crossing_flag & bus.wdata[2];
    end
    if (m1_cross) m1_d.crossing_flag = 1'b1;
  end

  always_comb begin
    m2_d = m2_q;
    if (hit(bus, MON2_CTL_OFS)) begin
      m2_d = svm_ctl_type'(bus.wdata);
      m2_d.unused = 3'h0;
      m2_d.action_sel = 1'b0;
      m2_d.filter_bypass = 1'b1;
      m2_d.crossing_flag = m2_q.crossing_flag & bus.wdata[2];
    end
    if (m2_cross) m2_d.crossing_flag = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      m1_q <= svm_ctl_type'(CTL_RST);
      m2_q <= svm_ctl_type'(CTL_RST);
    end else begin
      m1_q <= m1_d;
      m2_q <= m2_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) m0_en_q <= MON0_EN_RST;
    else if (hit(bus, MON0_CTL_OFS)) m0_en_q <= bus.wdata[MON0_EN_POS];
  end

  // ----------------------------------------------------------------
  // interrupt status, enable and output
  // ----------------------------------------------------------------
  always_comb begin
    ists_d = ists_q;
    if (hit(bus, INT_CLR_OFS)) ists_d = ists_q & ~bus.wdata[1:0];
    if (m1_irq_ev) ists_d[INT_MON1_POS] = 1'b1;
    if (m2_irq_ev) ists_d[INT_MON2_POS] = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ists_q <= INT_RST;
      ien_q <= INT_RST;
    end else begin
      ists_q <= ists_d;
      if (hit(bus, INT_EN_OFS)) ien_q <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) irq_q <= 1'b0;
    else irq_q <= |(ists_d & ien_q);
  end

  // ----------------------------------------------------------------
  // resets
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      por_rst_q <= 1'b1;
      mon0_rst_q <= 1'b0;
      mon1_rst_q <= 1'b0;
    end else begin
      if (lvl[0]) por_rst_q <= 1'b0;
      mon0_rst_q <= m0_en_q && !lvl[0];
      if (m1_rst_ev) mon1_rst_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    unique case (bus.addr)
      MON1_CTL_OFS: rd_mux = m1_q;
      MON2_CTL_OFS: rd_mux = m2_q;
      DET_STS_OFS: begin
        rd_mux[LVL0_POS] = lvl[0];
        rd_mux[LVL1_POS] = lvl[1];
        rd_mux[ABOVE2_POS] = lvl[2];
      end
      INT_STS_OFS: rd_mux[1:0] = ists_q;
      INT_EN_OFS: rd_mux[1:0] = ien_q;
      MON0_CTL_OFS: rd_mux[MON0_EN_POS] = m0_en_q;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) rdata_q <= '0;
    else if (bus.rd) rdata_q <= rd_mux;
    else rdata_q <= '0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_mon1_flag_set:
  assert property (@(posedge mclk) disable iff (srst)
    m1_cross |=> m1_q.crossing_flag)
  else $error("monitor 1 flag missed a crossing");

  a_mon2_flag_set:
  assert property (@(posedge mclk) disable iff (srst)
    m2_cross && !m2_q.request_en |=> m2_q.crossing_flag && !$rose(ists_q[INT_MON2_POS]))
  else $error("monitor 2 flag or request wrong while disabled");

  a_mon2_dir_up:
  assert property (@(posedge mclk) disable iff (srst)
    $rose(lvl[2]) && !m2_q.direction_sel |=> m2_q.crossing_flag)
  else $error("monitor 2 upward passage not flagged");

  a_mon1_dir_down:
  assert property (@(posedge mclk) disable iff (srst)
    $fell(lvl[1]) && m1_q.direction_sel |=> m1_q.crossing_flag)
  else $error("monitor 1 downward passage not flagged");

  a_mon1_irq_req:
  assert property (@(posedge mclk) disable iff (srst)
    m1_cross && m1_q.request_en && !m1_q.action_sel && ien_q[INT_MON1_POS] |=> ists_q[INT_MON1_POS] && irq_q)
  else $error("monitor 1 interrupt not raised");

  a_mon1_reset_route:
  assert property (@(posedge mclk) disable iff (srst)
    m1_cross && m1_q.request_en && m1_q.action_sel |=> mon1_rst_q)
  else $error("monitor 1 reset not raised");

  a_mon1_no_req:
  assert property (@(posedge mclk) disable iff (srst)
    !m1_q.request_en && !ists_q[INT_MON1_POS] && !mon1_rst_q |=> !ists_q[INT_MON1_POS] && !mon1_rst_q)
  else $error("monitor 1 request while disabled");

  a_mon0_reset:
  assert property (@(posedge mclk) disable iff (srst)
    m0_en_q && !lvl[0] |=> mon0_rst_q)
  else $error("level 0 monitor reset missing");

  a_por_release:
  assert property (@(posedge mclk) disable iff (srst)
    lvl[0] |=> !por_rst_q)
  else $error("power-on reset not released");

  a_status_live:
  assert property (@(posedge mclk) disable iff (srst)
    bus.rd && bus.addr == DET_STS_OFS |=> rdata_q[ABOVE2_POS] == $past(lvl[2]))
  else $error("level 2 status bit wrong");

  a_mon2_irq_req:
  assert property (@(posedge mclk) disable iff (srst)
    m2_cross && m2_q.request_en && ien_q[INT_MON2_POS] |=> ists_q[INT_MON2_POS] && irq_q)
  else $error("monitor 2 interrupt not raised");

  a_mon2_no_req:
  assert property (@(posedge mclk) disable iff (srst)
    !m2_q.request_en && !ists_q[INT_MON2_POS] |=> !ists_q[INT_MON2_POS])
  else $error("monitor 2 request while disabled");

  a_irq_level:
  assert property (@(posedge mclk) disable iff (srst)
    1'b1 |=> irq_q == |(ists_q & $past(ien_q)))
  else $error("interrupt output disagrees with status");

  a_mon1_flag_quiet:
  assert property (@(posedge mclk) disable iff (srst)
    $stable(lvl[1]) && !m1_q.crossing_flag |=> !m1_q.crossing_flag)
  else $error("monitor 1 flag set without a passage");

  a_mon2_flag_quiet:
  assert property (@(posedge mclk) disable iff (srst)
    $stable(lvl[2]) && !m2_q.crossing_flag |=> !m2_q.crossing_flag)
  else $error("monitor 2 flag set without a passage");

  a_mon2_dir_down:
  assert property (@(posedge mclk) disable iff (srst)
    $fell(lvl[2]) && m2_q.direction_sel |=> m2_q.crossing_flag)
  else $error("monitor 2 downward passage not flagged");

  a_mon1_dir_up:
  assert property (@(posedge mclk) disable iff (srst)
    $rose(lvl[1]) && !m1_q.direction_sel |=> m1_q.crossing_flag)
  else $error("monitor 1 upward passage not flagged");

  a_mon0_off:
  assert property (@(posedge mclk) disable iff (srst)
    !m0_en_q |=> !mon0_rst_q)
  else $error("level 0 monitor reset while disabled");

  a_mon0_above:
  assert property (@(posedge mclk) disable iff (srst)
    lvl[0] |=> !mon0_rst_q)
  else $error("level 0 monitor reset while supply above level");

  a_por_hold:
  assert property (@(posedge mclk) disable iff (srst)
    por_rst_q && !lvl[0] |=> por_rst_q)
  else $error("power-on reset released early");

  a_mon1_no_irq:
  assert property (@(posedge mclk) disable iff (srst)
    m1_q.action_sel && !ists_q[INT_MON1_POS] |=> !ists_q[INT_MON1_POS])
  else $error("monitor 1 interrupt while reset action chosen");

  a_mon1_rst_hold:
  assert property (@(posedge mclk) disable iff (srst)
    mon1_rst_q |=> mon1_rst_q)
  else $error("monitor 1 reset request dropped");

  a_filter_tick:
  assert property (@(posedge mclk) disable iff (srst)
    $changed(lvl[1]) && !$past(m1_q.filter_bypass) && !$past(m1_q.filter_bypass, 2) && !$past(srst)
    |-> $past(tick_q, 2))
  else $error("filtered level 1 changed off a sample tick");

  a_flag_sw_clear:
  assert property (@(posedge mclk) disable iff (srst)
    bus.wr && bus.addr == MON1_CTL_OFS && !bus.wdata[2] && !m1_cross |=> !m1_q.crossing_flag)
  else $error("monitor 1 flag not cleared by write");

  a_sync_lvl0:
  assert property (@(posedge mclk) disable iff (srst)
    $rose(lvl[0]) |-> $past(cmp_in[0], 3))
  else $error("level 0 rose without synchronised input");

  a_sync_lvl2:
  assert property (@(posedge mclk) disable iff (srst)
    $rose(lvl[2]) |-> $past(cmp_in[2], 3))
  else $error("level 2 rose without synchronised input");

endmodule
